// ===== verilog/aab_pkg.sv
// Package for the accumulator, arithmetic and branch core.
// Holds the register map, reset values, opcode encodings and the state layout.
// Assumes one 20 MHz clock and a classic Wishbone slave port in front of the core.

package aab_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 20000000;       // System clock rate
    localparam int unsigned CYCLE_CLKS  = 4;              // Clocks per machine cycle
    localparam logic [1:0]  PH_ADDR     = 2'h0;           // Drive program address
    localparam logic [1:0]  PH_WAIT     = 2'h1;           // Program memory latency
    localparam logic [1:0]  PH_LATCH    = 2'h2;           // Capture program byte
    localparam logic [1:0]  PH_EXEC     = 2'h3;           // Retire or advance

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CTRL    = 12'h000;        // Run, bank flag, timer flag
    localparam logic [11:0] REG_STATUS  = 12'h004;        // Read-only core snapshot
    localparam logic [11:0] REG_ACC     = 12'h008;        // Accumulator and carry
    localparam logic [11:0] REG_PC      = 12'h00c;        // Program counter
    localparam logic [3:0]  MEM_PAGE    = 4'h1;           // Data memory at 0x100..0x1fc

    // Control and accumulator bit positions
    localparam int unsigned CTRL_RUN    = 0;
    localparam int unsigned CTRL_BANK   = 1;
    localparam int unsigned CTRL_TFLAG  = 2;
    localparam int unsigned ACC_CARRY   = 8;

    // Reset values
    localparam logic [11:0] PC_RESET    = 12'h000;
    localparam logic [7:0]  ACC_RESET   = 8'h00;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ADD_IMM   = 8'h03;
    localparam logic [7:0] OP_ADD_WITH_CARRY_IMM = 8'h13;
    localparam logic [7:0] OP_AND_IMM   = 8'h53;
    localparam logic [7:0] OP_OR_IMM    = 8'h43;
    localparam logic [7:0] OP_XOR_IMM   = 8'hd3;
    localparam logic [3:0] NIB_ADD      = 4'h6;           // Register and indirect groups
    localparam logic [3:0] NIB_ADD_WITH_CARRY = 4'h7;
    localparam logic [3:0] NIB_AND      = 4'h5;
    localparam logic [3:0] NIB_OR       = 4'h4;
    localparam logic [3:0] NIB_XOR      = 4'hd;
    localparam logic [7:0] OP_CPL       = 8'h37;
    localparam logic [7:0] OP_CLR       = 8'h27;
    localparam logic [7:0] OP_DECIMAL_ADJUST = 8'h57;
    localparam logic [7:0] OP_INC       = 8'h17;
    localparam logic [7:0] OP_DEC       = 8'h07;
    localparam logic [7:0] OP_RL        = 8'he7;
    localparam logic [7:0] OP_RR        = 8'h77;
    localparam logic [7:0] OP_RLC       = 8'hf7;
    localparam logic [7:0] OP_RRC       = 8'h67;
    localparam logic [7:0] OP_SWAP      = 8'h47;
    localparam logic [4:0] GRP_DECREMENT_BRANCH = 5'h1d;  // Opcode bits 7-3
    localparam logic [4:0] GRP_JMP      = 5'h04;          // Opcode bits 4-0
    localparam logic [7:0] OP_INDIRECT_PAGE_JUMP = 8'hb3;
    localparam logic [7:0] OP_JC        = 8'hf6;
    localparam logic [7:0] OP_JNC       = 8'he6;
    localparam logic [7:0] OP_JZ        = 8'hc6;
    localparam logic [7:0] OP_JNZ       = 8'h96;
    localparam logic [7:0] OP_JUMP_TEST_HIGH      = 8'h56;
    localparam logic [7:0] OP_JUMP_TEST_LOW       = 8'h46;
    localparam logic [7:0] OP_JUMP_TIMER_OVERFLOW = 8'h16;

    // Decoded instruction kinds
    typedef enum {
        K_NOP, K_ADD, K_ADD_WITH_CARRY, K_AND, K_OR, K_XOR, K_CPL, K_CLR,
        K_DECIMAL_ADJUST, K_INC, K_DEC, K_RL, K_RR, K_RLC, K_RRC, K_SWAP,
        K_DECREMENT_BRANCH, K_JCOND, K_JMP, K_INDIRECT_PAGE_JUMP
    } aab_kind_e;

    // Whole state of the core
    typedef struct packed {
        logic [63:0][7:0] mem;      // Data memory, registers 0-7 at the bottom
        logic [1:0]       ph;       // Phase inside the machine cycle
        logic             second;   // In the second machine cycle
        logic [7:0]       opcode;   // Current instruction byte
        logic [7:0]       operand;  // Second instruction byte
        logic [11:0]      pc;       // Program counter
        logic [7:0]       acc;      // Accumulator
        logic             carry;    // Carry flag
        logic             run;      // Core enabled
        logic             bank;     // Memory bank flag
        logic             tflag;    // Timer overflow flag
        logic [11:0]      pm_addr;  // Program memory address out
        logic             wb_ack;   // Bus acknowledge
        logic [31:0]      wb_dat;   // Bus read data
    } aab_state_s;

endpackage

// ===== verilog/aab_core.sv
// Accumulator arithmetic and branch core with a Wishbone register port.
// Assumes a synchronous program memory whose byte is valid one clock after
// the address, and a test input already synchronous to clk.
//
// Operation
// - Add immediate, register, indirect; update carry
// - Add with carry, three operand forms
// - AND operand into accumulator, carry kept
// - OR operand into accumulator, carry kept
// - XOR operand into accumulator, carry kept
// - Complement or clear accumulator, carry kept
// - Decimal adjust accumulator, update carry
// - Increment or decrement accumulator, wrapping
// - Rotate accumulator left or right
// - Rotate left or right through carry
// - Swap accumulator nibbles
// - Register in bits 2-0, pointer bit 0
// - Decrement register, branch in page if nonzero
// - Jump on carry set or clear
// - Jump on accumulator zero or nonzero
// - Jump on test input high or low
// - Jump on timer overflow flag set
// - Direct jump, bank flag into bit 11
// - Indirect jump through page table byte
//
// Design decisions made here: register access over Wishbone and the register offsets.

`timescale 1ns/1ps

module aab_core (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [11:0] pm_addr,
    input  wire logic [7:0]  pm_data,
    input  wire logic        test_one_input
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Immediate, register or indirect member of an ALU group
    function automatic logic alu_group(input logic [7:0] op, input logic [7:0] imm,
                                       input logic [3:0] nib);
        alu_group = (op == imm) || ((op[7:4] == nib) && (op[3] || (op[2:1] == 2'b00)));
    endfunction

    // Map an opcode to its kind; anything else runs as a one-cycle no-op
    function automatic aab_pkg::aab_kind_e decode_kind(input logic [7:0] op);
        decode_kind = aab_pkg::K_NOP;
        if (alu_group(op, aab_pkg::OP_ADD_IMM, aab_pkg::NIB_ADD))
            decode_kind = aab_pkg::K_ADD;
        else if (alu_group(op, aab_pkg::OP_ADD_WITH_CARRY_IMM, aab_pkg::NIB_ADD_WITH_CARRY))
            decode_kind = aab_pkg::K_ADD_WITH_CARRY;
        else if (alu_group(op, aab_pkg::OP_AND_IMM, aab_pkg::NIB_AND))
            decode_kind = aab_pkg::K_AND;
        else if (alu_group(op, aab_pkg::OP_OR_IMM, aab_pkg::NIB_OR))
            decode_kind = aab_pkg::K_OR;
        else if (alu_group(op, aab_pkg::OP_XOR_IMM, aab_pkg::NIB_XOR))
            decode_kind = aab_pkg::K_XOR;
        else if (op == aab_pkg::OP_CPL)     decode_kind = aab_pkg::K_CPL;
        else if (op == aab_pkg::OP_CLR)     decode_kind = aab_pkg::K_CLR;
        else if (op == aab_pkg::OP_DECIMAL_ADJUST)
            decode_kind = aab_pkg::K_DECIMAL_ADJUST;
        else if (op == aab_pkg::OP_INC)     decode_kind = aab_pkg::K_INC;
        else if (op == aab_pkg::OP_DEC)     decode_kind = aab_pkg::K_DEC;
        else if (op == aab_pkg::OP_RL)      decode_kind = aab_pkg::K_RL;
        else if (op == aab_pkg::OP_RR)      decode_kind = aab_pkg::K_RR;
        else if (op == aab_pkg::OP_RLC)     decode_kind = aab_pkg::K_RLC;
        else if (op == aab_pkg::OP_RRC)     decode_kind = aab_pkg::K_RRC;
        else if (op == aab_pkg::OP_SWAP)    decode_kind = aab_pkg::K_SWAP;
        else if (op[7:3] == aab_pkg::GRP_DECREMENT_BRANCH)
            decode_kind = aab_pkg::K_DECREMENT_BRANCH;
        // Conditional in-page jumps share one kind; the condition is picked later
        else if (op == aab_pkg::OP_JC  || op == aab_pkg::OP_JNC ||
                 op == aab_pkg::OP_JZ  || op == aab_pkg::OP_JNZ ||
                 op == aab_pkg::OP_JUMP_TEST_HIGH || op == aab_pkg::OP_JUMP_TEST_LOW ||
                 op == aab_pkg::OP_JUMP_TIMER_OVERFLOW)
            decode_kind = aab_pkg::K_JCOND;
        else if (op[4:0] == aab_pkg::GRP_JMP) decode_kind = aab_pkg::K_JMP;
        else if (op == aab_pkg::OP_INDIRECT_PAGE_JUMP)
            decode_kind = aab_pkg::K_INDIRECT_PAGE_JUMP;
    endfunction

    // ALU groups with an immediate byte end in nibble 3
    function automatic logic is_alu_imm(input logic [7:0] op);
        aab_pkg::aab_kind_e k;
        k = decode_kind(op);
        is_alu_imm = (op[3:0] == aab_pkg::OP_ADD_IMM[3:0]) &&
                     (k == aab_pkg::K_ADD || k == aab_pkg::K_ADD_WITH_CARRY ||
                      k == aab_pkg::K_AND ||
                      k == aab_pkg::K_OR  || k == aab_pkg::K_XOR);
    endfunction

    // Instructions that take a second machine cycle
    function automatic logic two_cycle(input logic [7:0] op);
        aab_pkg::aab_kind_e k;
        k = decode_kind(op);
        two_cycle = is_alu_imm(op) || k == aab_pkg::K_DECREMENT_BRANCH ||
                    k == aab_pkg::K_JCOND || k == aab_pkg::K_JMP ||
                    k == aab_pkg::K_INDIRECT_PAGE_JUMP;
    endfunction

    // Only the low 11 bits count; bit 11 holds the bank
    function automatic logic [11:0] pc_inc(input logic [11:0] pc);
        pc_inc = {pc[11], pc[10:0] + 11'h001};
    endfunction

    function automatic logic [8:0] dec_adjust(input logic [7:0] a, input logic c);
        logic [8:0] t;
        t = {1'b0, a};
        if (t[3:0] > 4'h9)
            t = t + 9'h006;
        if ((t[7:4] > 4'h9) || t[8] || c)
            t = t + 9'h060;
        dec_adjust = {t[8] | c, t[7:0]};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    aab_pkg::aab_state_s st;        // Registered state
    aab_pkg::aab_state_s next_st;   // Next state

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Bus slave first, then the core; the core never touches what the bus may write
    always_comb begin
        aab_pkg::aab_kind_e kind;
        logic [7:0]         reg_val;
        logic [7:0]         ind_val;
        logic [7:0]         src;
        logic [8:0]         sum;
        logic               cin;
        logic               cond;
        logic [7:0]         decrement_branch_nonzero_val;
        logic               bus_req;
        next_st  = st;
        kind     = decode_kind(st.opcode);
        reg_val  = st.mem[{3'h0, st.opcode[2:0]}];
        ind_val  = st.mem[st.mem[{5'h00, st.opcode[0]}][5:0]];
        src      = 8'h00;
        sum      = 9'h000;
        cin      = 1'b0;
        cond     = 1'b0;
        decrement_branch_nonzero_val = reg_val - 8'h01;
        bus_req  = wb_cyc_i && wb_stb_i && !st.wb_ack;

        // Ack drops the cycle after it was given
        next_st.wb_ack = bus_req;
        next_st.wb_dat = 32'h0000_0000;
        if (bus_req) begin
            if (wb_adr_i[11:8] == aab_pkg::MEM_PAGE) begin
                // Data memory; writes only while halted to avoid racing the core
                next_st.wb_dat = {24'h00_0000, st.mem[wb_adr_i[7:2]]};
                if (wb_we_i && wb_sel_i[0] && !st.run) begin
                    next_st.mem[wb_adr_i[7:2]] = wb_dat_i[7:0];
                end
            end else begin
                unique case (wb_adr_i)
                    aab_pkg::REG_CTRL: begin
                        next_st.wb_dat = {29'h0, st.tflag, st.bank, st.run};
                        if (wb_we_i && wb_sel_i[0]) begin
                            next_st.run   = wb_dat_i[aab_pkg::CTRL_RUN];
                            next_st.bank  = wb_dat_i[aab_pkg::CTRL_BANK];
                            next_st.tflag = wb_dat_i[aab_pkg::CTRL_TFLAG];
                        end
                    end
                    aab_pkg::REG_STATUS: begin
                        // Snapshot of phase, cycle, opcode and pc
                        next_st.wb_dat = {9'h000, st.ph, st.second, st.opcode, st.pc};
                    end
                    aab_pkg::REG_ACC: begin
                        next_st.wb_dat = {23'h00_0000, st.carry, st.acc};
                        if (wb_we_i && !st.run) begin
                            if (wb_sel_i[0]) next_st.acc   = wb_dat_i[7:0];
                            if (wb_sel_i[1]) next_st.carry = wb_dat_i[aab_pkg::ACC_CARRY];
                        end
                    end
                    aab_pkg::REG_PC: begin
                        next_st.wb_dat = {20'h0_0000, st.pc};
                        if (wb_we_i && !st.run) begin
                            if (wb_sel_i[0]) next_st.pc[7:0]  = wb_dat_i[7:0];
                            if (wb_sel_i[1]) next_st.pc[11:8] = wb_dat_i[11:8];
                        end
                    end
                    default: begin
                        // Unmapped: acked, reads zero, writes dropped
                        next_st.wb_dat = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Core advances one phase per clock while running
        if (st.run) begin
            next_st.ph = st.ph + 2'h1;
            unique case (st.ph)
                aab_pkg::PH_ADDR: begin
                    if (st.second && kind == aab_pkg::K_INDIRECT_PAGE_JUMP) begin
                        next_st.pm_addr = {st.pc[11:8], st.acc};
                    end else begin
                        next_st.pm_addr = st.pc;
                    end
                end
                aab_pkg::PH_WAIT: begin
                    // Program memory settles
                end
                aab_pkg::PH_LATCH: begin
                    if (!st.second) begin
                        next_st.opcode = pm_data;
                        next_st.pc     = pc_inc(st.pc);
                    end else begin
                        next_st.operand = pm_data;
                        // Table fetch does not consume a program byte
                        if (kind != aab_pkg::K_INDIRECT_PAGE_JUMP) begin
                            next_st.pc = pc_inc(st.pc);
                        end
                    end
                end
                aab_pkg::PH_EXEC: begin
                    if (!st.second && two_cycle(st.opcode)) begin
                        next_st.second = 1'b1;
                    end else begin
                        next_st.second = 1'b0;
                        // Operand source: immediate, register or indirect
                        if (is_alu_imm(st.opcode)) src = st.operand;
                        else if (st.opcode[3]) src = reg_val;
                        else src = ind_val;
                        cin = (kind == aab_pkg::K_ADD_WITH_CARRY) ? st.carry : 1'b0;
                        sum = {1'b0, st.acc} + {1'b0, src} + {8'h00, cin};
                        unique case (kind)
                            aab_pkg::K_ADD, aab_pkg::K_ADD_WITH_CARRY: begin
                                next_st.acc   = sum[7:0];
                                next_st.carry = sum[8];
                            end
                            aab_pkg::K_AND: next_st.acc = st.acc & src;
                            aab_pkg::K_OR:  next_st.acc = st.acc | src;
                            aab_pkg::K_XOR: next_st.acc = st.acc ^ src;
                            aab_pkg::K_CPL: next_st.acc = ~st.acc;
                            aab_pkg::K_CLR: next_st.acc = 8'h00;
                            aab_pkg::K_DECIMAL_ADJUST: begin
                                {next_st.carry, next_st.acc} = dec_adjust(st.acc, st.carry);
                            end
                            aab_pkg::K_INC: next_st.acc = st.acc + 8'h01;
                            aab_pkg::K_DEC: next_st.acc = st.acc - 8'h01;
                            aab_pkg::K_RL:  next_st.acc = {st.acc[6:0], st.acc[7]};
                            aab_pkg::K_RR:  next_st.acc = {st.acc[0], st.acc[7:1]};
                            aab_pkg::K_RLC: begin
                                next_st.acc   = {st.acc[6:0], st.carry};
                                next_st.carry = st.acc[7];
                            end
                            aab_pkg::K_RRC: begin
                                next_st.acc   = {st.carry, st.acc[7:1]};
                                next_st.carry = st.acc[0];
                            end
                            aab_pkg::K_SWAP: next_st.acc = {st.acc[3:0], st.acc[7:4]};
                            aab_pkg::K_DECREMENT_BRANCH: begin
                                next_st.mem[{3'h0, st.opcode[2:0]}] = decrement_branch_nonzero_val;
                                if (decrement_branch_nonzero_val != 8'h00) next_st.pc[7:0] = st.operand;
                            end
                            aab_pkg::K_JCOND: begin
                                if (st.opcode == aab_pkg::OP_JC)   cond = st.carry;
                                if (st.opcode == aab_pkg::OP_JNC)  cond = !st.carry;
                                if (st.opcode == aab_pkg::OP_JZ)   cond = (st.acc == 8'h00);
                                if (st.opcode == aab_pkg::OP_JNZ)  cond = (st.acc != 8'h00);
                                if (st.opcode == aab_pkg::OP_JUMP_TEST_HIGH)
                                    cond = test_one_input;
                                if (st.opcode == aab_pkg::OP_JUMP_TEST_LOW)
                                    cond = !test_one_input;
                                if (st.opcode == aab_pkg::OP_JUMP_TIMER_OVERFLOW)
                                    cond = st.tflag;
                                // taken loads low byte, else pc already +2
                                if (cond) next_st.pc[7:0] = st.operand;
                            end
                            aab_pkg::K_JMP: begin
                                // bank, opcode bits 7-5, byte two
                                next_st.pc = {st.bank, st.opcode[7:5], st.operand};
                            end
                            aab_pkg::K_INDIRECT_PAGE_JUMP: begin
                                next_st.pc[7:0] = st.operand;
                            end
                            aab_pkg::K_NOP: begin
                                // Unhandled opcodes retire without effect
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Synchronous reset; data memory is cleared so reads are defined
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st         <= '0;
            st.pc      <= aab_pkg::PC_RESET;
            st.pm_addr <= aab_pkg::PC_RESET;
            st.acc     <= aab_pkg::ACC_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign wb_dat_o = st.wb_dat;
    assign wb_ack_o = st.wb_ack;
    assign pm_addr  = st.pm_addr;

endmodule

// ===== tb/aab_core_properties.sv
// Port checks on aab_core: bus answer timing and fetch spacing
// Bound to every aab_core; one clock, synchronous active-low reset
`timescale 1ns/1ps
module aab_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [11:0] pm_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("ack unasked");
    ack_stb_low_a: assert property (!wb_stb_i |=> !wb_ack_o) else $error("ack sans stb");
    ack_cyc_low_a: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("ack sans cyc");
    // Fetch address holds a full machine cycle of four clocks
    fetch_hold_a: assert property ($changed(pm_addr) |=> $stable(pm_addr) [*3])
        else $error("fetch too fast");
    reset_idle_a: assert property ($rose(rst_n) |-> pm_addr == 12'h000 && !wb_ack_o)
        else $error("reset state");
    unmapped_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h010)
        |-> wb_dat_o == 32'h0) else $error("unmapped data");
endmodule

bind aab_core aab_chk chk_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pm_addr(pm_addr));

// ===== tb/aab_rom.sv
// Program memory model: synchronous, byte valid one clock after address
// The bench preloads bytes through mem; unwritten bytes run as no-ops
`timescale 1ns/1ps
module aab_rom (
    input  wire logic        clk,
    input  wire logic [11:0] addr,
    output logic      [7:0]  data
);
    logic [7:0] mem [4096];  // Program bytes
    initial foreach (mem[i]) mem[i] = 8'h00;
    // One clock of read latency, as the core expects
    always_ff @(posedge clk) begin
        data <= mem[addr];
    end
endmodule

// ===== tb/test_acc_alu_branch_decoder.sv
// Bench for aab_core: opcode table, reset values, bus corner cases
// Program bytes come from aab_rom; registers reached over classic Wishbone
`timescale 1ns/1ps
module test_acc_alu_branch_decoder;
    logic        clk, rst_n, cyc, stb, we, test_in, ack;
    logic [11:0] adr, pma;
    logic [31:0] wdat, rdat, rd;
    logic [7:0]  pmd;
    int          num_errors = 0;
    int          num_checks = 0;
    // Opcode, byte two, acc in, carry in, acc out, carry out, pc after
    logic [51:0] rows [33] = '{
        52'h03_f0_20_0_10_1_003, 52'h13_01_fe_1_00_1_003, 52'h53_0f_3c_1_0c_1_003,
        52'h43_81_3c_0_bd_0_003, 52'hd3_ff_3c_1_c3_1_003, 52'h69_00_fd_0_02_1_003,
        52'h71_00_10_1_44_0_003, 52'h59_00_ff_0_05_0_003, 52'h41_00_40_0_73_0_003,
        52'hd9_00_05_1_00_1_003, 52'h37_00_5a_1_a5_1_003, 52'h27_00_5a_0_00_0_003,
        52'h57_00_9b_0_01_1_003, 52'h57_00_12_1_72_1_003, 52'h17_00_ff_1_00_1_003,
        52'h07_00_00_0_ff_0_003, 52'he7_00_81_0_03_0_003, 52'h77_00_81_0_c0_0_003,
        52'hf7_00_80_0_00_1_003, 52'hf7_00_01_1_03_0_003, 52'h67_00_01_0_00_1_003,
        52'h47_00_3c_0_c3_0_003, 52'hf6_40_00_1_00_1_041, 52'he6_40_00_1_00_1_003,
        52'hc6_40_00_0_00_0_041, 52'h96_40_01_0_01_0_041, 52'h56_40_00_1_00_1_041,
        52'h46_40_00_0_00_0_041, 52'h16_40_00_1_00_1_041, 52'ha4_30_00_1_00_1_d31,
        52'hb3_60_01_0_01_0_061, 52'hea_40_00_0_00_0_003, 52'heb_40_00_0_00_0_041};
    aab_core dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pm_addr(pma), .pm_data(pmd), .test_one_input(test_in));
    aab_rom rom_u (.clk(clk), .addr(pma), .data(pmd));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One classic cycle; request held until ack is sampled, then dropped
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        if (n >= 20) begin
            num_errors++;
            tally_and_finish();
        end
        {cyc, stb} <= 2'b00;
    endtask
    // Run from pc 0 for exactly twelve clocks, three machine cycles
    task automatic run_row(input logic [51:0] r);
        rom_u.mem[0] = r[51:44];
        rom_u.mem[1] = r[43:36];
        test_in <= r[24];
        bus(1'b1, 12'h00c, 32'h0);
        bus(1'b1, 12'h008, {23'h0, r[24], r[35:28]});
        bus(1'b1, 12'h000, {29'h0, r[24], r[24], 1'b1});
        repeat (9) @(posedge clk);
        bus(1'b1, 12'h000, 32'h0);
        bus(1'b0, 12'h008, 32'h0);
        check(rd & 32'h1ff, {23'h0, r[12], r[23:16]});
        bus(1'b0, 12'h004, 32'h0);
        check(rd & 32'h7fffff, {20'h0, r[11:0]});
    endtask
    initial begin
        {rst_n, cyc, stb, we, test_in, adr, wdat} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            bus(1'b0, 12'(a * 4), 32'h0);
            check(rd & 32'h7fffff, 32'h0);
        end
        // Register 1 = 5, register 2 = 1, data byte 5 = 0x33
        bus(1'b1, 12'h104, 32'h05);
        bus(1'b1, 12'h108, 32'h01);
        bus(1'b1, 12'h114, 32'h33);
        foreach (rows[i]) run_row(rows[i]);
        // Unmapped word: acked, reads zero, write lost
        bus(1'b1, 12'h010, 32'hffff_ffff);
        bus(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0);
        // Accumulator write while running must be dropped
        bus(1'b1, 12'h00c, 32'h200);
        bus(1'b1, 12'h008, 32'h05a);
        bus(1'b1, 12'h000, 32'h1);
        bus(1'b1, 12'h008, 32'h011);
        bus(1'b1, 12'h000, 32'h0);
        bus(1'b0, 12'h008, 32'h0);
        check(rd & 32'h1ff, 32'h05a);
        // Reset in mid-run clears accumulator and control, core halted
        bus(1'b1, 12'h000, 32'h7);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        tally_and_finish();
    end
endmodule
